//--- jnp_nvm_prog.sv
// Device-side JTAG programming command engine for Flash, EEPROM and fuses
`timescale 1ns/1ps
`default_nettype none
module jnp_nvm_prog
    import jnp_pkg::*;
#(
    parameter int          FLASH_AW  = 10,         // Flash word address bits
    parameter int          PAGE_AW   = 5,          // Log2 of words per page
    parameter int          EE_AW     = 9,          // EEPROM address bits
    parameter logic [23:0] SIG_BYTES = 24'h3c_a5_5a, // Arbitrary value
    parameter logic [7:0]  CAL_BYTE  = 8'h5a,        // Arbitrary value
    parameter int          WRITE_CYC = WRITE_WAIT_US * REF_CLK_MHZ,
    parameter int          ERASE_CYC = ERASE_WAIT_US * REF_CLK_MHZ
) (
    input  wire logic            ref_clk_i,
    input  wire logic            nrst_i,
    input  wire logic            tck_i,
    input  wire logic            tdi_i,
    input  wire logic [IR_W-1:0] instr_i,
    input  wire jnp_tap_type     tap_i,
    output var  logic            tdo_o,
    output var  logic            cpu_hold_reset_o,
    output var  logic            prog_active_o,
    output var  logic            nvm_busy_o
);
    localparam int PW = 1 << PAGE_AW;
    // Refuse shapes the logic cannot serve
    if (PAGE_AW < 1 || PAGE_AW >= FLASH_AW || FLASH_AW > 16 || EE_AW > 16) begin : g_bad_size
        $error("Unsupported memory geometry");
    end
    if (WRITE_CYC < 1 || ERASE_CYC < 1 || WRITE_CYC >= 2**CNT_W || ERASE_CYC >= 2**CNT_W) begin : g_bad_time
        $error("Wait counts out of counter range");
    end

    // Settled value of a three-stage synchroniser
    function automatic logic [1:0] settle(logic [1:0] s2, logic [1:0] s3, logic [1:0] f);
        return (~(s2 ^ s3) & s3) | ((s2 ^ s3) & f);
    endfunction : settle

    // ****************************************
    // Test clock domain state
    // ****************************************
    logic [15:0]        flash_mem [2**FLASH_AW]; // Flash array
    logic [15:0]        page_buf  [PW];          // Flash page buffer
    logic [7:0]         ee_mem    [2**EE_AW];    // EEPROM array
    logic [15:0]        sh_q;        // Shared data register shifter
    logic               hold_q;      // CPU hold reset register
    logic [15:0]        key_q;       // Programming key register
    logic               prog_q;      // Programming mode active
    logic [7:0]         mode_q;      // Current mode byte
    logic [7:0]         ahi_q;       // Address high byte
    logic [7:0]         alo_q;       // Address low byte
    logic [7:0]         dlo_q;       // Data low byte
    logic [7:0]         dhi_q;       // Data high byte
    logic [14:0]        last_q;      // Previous command word
    logic [7:0]         fuse_q [3];  // Low, high, extended fuses
    logic [7:0]         lock_q;      // Lock bits
    logic [2:0]         bit_cnt_q;   // Bit within current page byte
    logic [PAGE_AW:0]   byte_idx_q;  // Byte within page
    logic               dump_fill_q; // Filler bits still leaving
    logic [1:0]         start_q;     // Toggles: bit0 write, bit1 erase
    logic [1:0]         dsync_q [3]; // Done toggles coming back
    logic [1:0]         done_f_q;    // Settled done toggles
    logic [1:0]         done_q;      // Done toggles sent back, reference clock side

    // ****************************************
    // Command decode
    // ****************************************
    jnp_cmd_type cmd;
    assign cmd = sh_q[14:0];
    wire logic [FLASH_AW-1:0] faddr = FLASH_AW'({ahi_q, alo_q});
    wire logic [EE_AW-1:0]    eaddr = EE_AW'({ahi_q, alo_q});
    wire logic [FLASH_AW-PAGE_AW-1:0] page = faddr[FLASH_AW-1:PAGE_AW];
    wire logic busy_t  = |(start_q ^ done_f_q);
    wire logic upd_cmd = tap_i.update && instr_i == IR_CMD && prog_q;
    // Strobe edges against the previous word, so prep words are required
    wire logic wr_stb  = upd_cmd && cmd.op[6:4] == OP_RW && !cmd.op[1]
                         && last_q[BIT_WR] && !busy_t;
    wire logic latch   = upd_cmd && cmd.op[6] && !last_q[BIT_LATCH];
    wire logic [1:0] bs_rd = {last_q[BIT_BS2], last_q[BIT_BS1]};
    wire logic [1:0] bs_wr = {cmd.op[3], cmd.op[2]};
    wire logic [15:0] fword = flash_mem[faddr];
    // Read selection by mode and previous word
    wire logic [7:0] sig_b  = alo_q == 8'h00 ? SIG_BYTES[7:0] :
                              alo_q == 8'h01 ? SIG_BYTES[15:8] :
                              alo_q == 8'h02 ? SIG_BYTES[23:16] : 8'h00;
    wire logic [7:0] fuse_b = bs_rd == 2'b10 ? fuse_q[2] : bs_rd == 2'b11 ? fuse_q[1] :
                              bs_rd == 2'b00 ? fuse_q[0] : lock_q;
    wire logic [7:0] rd_b   = mode_q == MODE_FRD  ? (last_q[BIT_BS1] ? fword[15:8] : fword[7:0]) :
                              mode_q == MODE_ERD  ? ee_mem[eaddr] :
                              mode_q == MODE_FLRD ? fuse_b :
                              mode_q == MODE_SIG  ? (last_q[BIT_BS1] ? CAL_BYTE : sig_b) : 8'h00;
    wire logic [14:0] cap_w = {5'h00, ~busy_t, 1'b0, rd_b};
    // Page byte path
    wire logic p_bnd  = tap_i.shift && bit_cnt_q == 3'h7;
    wire logic fill_w = p_bnd && instr_i == IR_FILL && prog_q && mode_q == MODE_FWR;
    wire logic dump_l = p_bnd && instr_i == IR_DUMP;
    wire logic [15:0] dword = flash_mem[{page, byte_idx_q[PAGE_AW:1]}];
    wire logic [7:0]  dbyte = (prog_q && mode_q == MODE_FRD)
                              ? (byte_idx_q[0] ? dword[15:8] : dword[7:0]) : 8'h00;
    // Shifter next value, each register at its own length
    wire logic [15:0] sh_sft = instr_i == IR_KEY  ? {tdi_i, sh_q[15:1]} :
                               instr_i == IR_CMD  ? {1'b0, tdi_i, sh_q[14:1]} :
                               instr_i == IR_HOLD ? {15'h0000, tdi_i} :
                               {8'h00, tdi_i, sh_q[7:1]};
    wire logic [15:0] sh_cap = instr_i == IR_KEY  ? key_q :
                               instr_i == IR_CMD  ? {1'b0, cap_w} :
                               instr_i == IR_HOLD ? {15'h0000, hold_q} : 16'h0000;
    wire logic [15:0] sh_d   = tap_i.capture ? sh_cap :
                               dump_l ? {8'h00, dbyte} :
                               tap_i.shift ? sh_sft : sh_q;

    // Shifter and serial output
    always_ff @(posedge tck_i) begin
        if (tap_i.reset) begin
            sh_q  <= 16'h0000;
            tdo_o <= 1'b0;
        end else begin
            sh_q  <= sh_d;
            tdo_o <= sh_d[0];
        end
    end

    // Hold and key registers; mode needs both
    always_ff @(posedge tck_i) begin
        if (tap_i.reset) begin
            hold_q <= 1'b0;
            key_q  <= 16'h0000;
            prog_q <= 1'b0;
        end else begin
            if (tap_i.update && instr_i == IR_HOLD) begin
                hold_q <= sh_q[0];
            end
            if (tap_i.update && instr_i == IR_KEY) begin
                key_q <= sh_q;
            end
            prog_q <= hold_q && key_q == PROG_KEY;
        end
    end

    // Command register file, fuses and lock bits
    always_ff @(posedge tck_i) begin
        if (tap_i.reset) begin
            mode_q <= MODE_NOP;
            ahi_q  <= 8'h00;
            alo_q  <= 8'h00;
            dlo_q  <= 8'h00;
            dhi_q  <= 8'h00;
            last_q <= 15'h0000;
            fuse_q <= '{FUSE_RST, FUSE_RST, FUSE_RST};
            lock_q <= LOCK_RST;
        end else if (upd_cmd) begin
            last_q <= cmd;
            case (cmd.op)
                OP_MODE: mode_q <= cmd.arg;
                OP_AHI:  ahi_q  <= cmd.arg;
                OP_ALO:  alo_q  <= cmd.arg;
                OP_DLO:  dlo_q  <= cmd.arg;
                OP_DHI:  dhi_q  <= cmd.arg;
                default: ;
            endcase
            if (wr_stb && mode_q == MODE_FUSEW) begin
                // Stored as written: zero means programmed
                fuse_q[bs_wr == 2'b10 ? 2 : bs_wr == 2'b01 ? 1 : 0] <= dlo_q;
            end
            if (wr_stb && mode_q == MODE_LOCKW) begin
                lock_q <= lock_q & dlo_q;
            end
            if (wr_stb && mode_q == MODE_ERASE) begin
                lock_q <= LOCK_RST;
            end
        end
    end

    // Memory writes; arrays carry no reset, erase defines Flash and EEPROM
    always_ff @(posedge tck_i) begin
        if (latch && mode_q == MODE_FWR) begin
            page_buf[faddr[PAGE_AW-1:0]] <= {dhi_q, dlo_q};
        end
        if (latch && mode_q == MODE_EWR) begin
            ee_mem[eaddr] <= dlo_q;
        end
        if (fill_w && byte_idx_q[0]) begin
            page_buf[byte_idx_q[PAGE_AW:1]][15:8] <= {tdi_i, sh_q[7:1]};
        end
        if (fill_w && !byte_idx_q[0]) begin
            page_buf[byte_idx_q[PAGE_AW:1]][7:0] <= {tdi_i, sh_q[7:1]};
        end
        if (wr_stb && mode_q == MODE_FWR) begin
            for (int i = 0; i < PW; i++) begin
                flash_mem[{page, PAGE_AW'(i)}] <= page_buf[i];
            end
        end
        if (wr_stb && mode_q == MODE_ERASE) begin
            for (int i = 0; i < 2**FLASH_AW; i++) begin
                flash_mem[i] <= 16'hffff;
            end
            for (int i = 0; i < 2**EE_AW; i++) begin
                ee_mem[i] <= 8'hff;
            end
        end
    end

    // Page byte counters for fill and dump
    always_ff @(posedge tck_i) begin
        if (tap_i.reset || tap_i.capture) begin
            bit_cnt_q   <= 3'h0;
            byte_idx_q  <= '0;
            dump_fill_q <= !tap_i.reset && instr_i == IR_DUMP;
        end else if (tap_i.shift) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (p_bnd) begin
                byte_idx_q  <= byte_idx_q + 1'b1;
                dump_fill_q <= 1'b0;
            end
        end
    end

    // Start toggles out, done toggles back through three flops
    always_ff @(posedge tck_i) begin
        if (tap_i.reset) begin
            start_q  <= 2'b00;
            dsync_q  <= '{2'b00, 2'b00, 2'b00};
            done_f_q <= 2'b00;
        end else begin
            if (wr_stb && (mode_q == MODE_FWR || mode_q == MODE_EWR ||
                           mode_q == MODE_FUSEW || mode_q == MODE_LOCKW)) begin
                start_q[0] <= ~start_q[0];
            end
            if (wr_stb && mode_q == MODE_ERASE) begin
                start_q[1] <= ~start_q[1];
            end
            dsync_q  <= '{done_q, dsync_q[0], dsync_q[1]};
            done_f_q <= settle(dsync_q[1], dsync_q[2], done_f_q);
        end
    end

    // ****************************************
    // Reference clock domain: write timing
    // ****************************************
    logic [1:0]       ssync_q [3]; // Start toggles arriving
    logic [1:0]       start_f_q;   // Settled start toggles
    logic [1:0]       seen_q;      // Start toggles already served
    logic [1:0]       lsync_q [3]; // Hold and mode levels arriving
    logic [CNT_W-1:0] cnt_q;       // Remaining wait cycles
    jnp_state_type    state_q;
    wire logic [1:0] evt = start_f_q ^ seen_q;
    // Pass a level pair through the filter to the ports
    wire logic [1:0] lvl = settle(lsync_q[1], lsync_q[2], {cpu_hold_reset_o, prog_active_o});

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ssync_q          <= '{2'b00, 2'b00, 2'b00};
            lsync_q          <= '{2'b00, 2'b00, 2'b00};
            start_f_q        <= 2'b00;
            cpu_hold_reset_o <= 1'b0;
            prog_active_o    <= 1'b0;
        end else begin
            ssync_q          <= '{start_q, ssync_q[0], ssync_q[1]};
            lsync_q          <= '{{hold_q, prog_q}, lsync_q[0], lsync_q[1]};
            start_f_q        <= settle(ssync_q[1], ssync_q[2], start_f_q);
            cpu_hold_reset_o <= lvl[1];
            prog_active_o    <= lvl[0];
        end
    end

    // Busy sequencer, one operation at a time
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_q    <= ST_IDLE;
            cnt_q      <= '0;
            seen_q     <= 2'b00;
            done_q     <= 2'b00;
            nvm_busy_o <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (evt[1]) begin
                        state_q    <= ST_ERASE;
                        cnt_q      <= CNT_W'(ERASE_CYC - 1);
                        seen_q[1]  <= start_f_q[1];
                        nvm_busy_o <= 1'b1;
                    end else if (evt[0]) begin
                        state_q    <= ST_WRITE;
                        cnt_q      <= CNT_W'(WRITE_CYC - 1);
                        seen_q[0]  <= start_f_q[0];
                        nvm_busy_o <= 1'b1;
                    end
                end
                ST_WRITE, ST_ERASE: begin
                    if (cnt_q == '0) begin
                        state_q    <= ST_IDLE;
                        done_q     <= seen_q;
                        nvm_busy_o <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q    <= ST_IDLE;
                    nvm_busy_o <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_sig_cap;
        mode_q == MODE_SIG && tap_i.capture && instr_i == IR_CMD && prog_q;
    endsequence
    sequence s_dump_run;
        (tap_i.capture && instr_i == IR_DUMP) ##1 (tap_i.shift && instr_i == IR_DUMP)[*8];
    endsequence
    property p_locked_out;
        @(posedge tck_i) disable iff (tap_i.reset)
        (tap_i.update && instr_i == IR_CMD && !prog_q) |=> $stable(mode_q) && $stable(alo_q);
    endproperty
    a_locked_out: assert property (p_locked_out) else $error("Command taken while locked");
    property p_nop;
        @(posedge tck_i) disable iff (tap_i.reset)
        (upd_cmd && cmd == {OP_MODE, MODE_NOP}) |=> mode_q == MODE_NOP && !wr_stb;
    endproperty
    a_nop: assert property (p_nop) else $error("No-operation did not cancel");
    property p_sig_mode;
        @(posedge tck_i) disable iff (tap_i.reset)
        (upd_cmd && cmd == {OP_MODE, MODE_SIG}) |=> mode_q == MODE_SIG;
    endproperty
    a_sig_mode: assert property (p_sig_mode) else $error("Signature mode not entered");
    property p_sig_byte;
        @(posedge tck_i) disable iff (tap_i.reset)
        (s_sig_cap and !last_q[BIT_BS1]) |=> sh_q[7:0] == $past(sig_b);
    endproperty
    a_sig_byte: assert property (p_sig_byte) else $error("Wrong signature byte");
    property p_cal_byte;
        @(posedge tck_i) disable iff (tap_i.reset)
        (s_sig_cap and last_q[BIT_BS1]) |=> sh_q[7:0] == CAL_BYTE;
    endproperty
    a_cal_byte: assert property (p_cal_byte) else $error("Wrong calibration byte");
    property p_fuse_high_rd;
        @(posedge tck_i) disable iff (tap_i.reset)
        (mode_q == MODE_FLRD && bs_rd == 2'b11 && tap_i.capture && instr_i == IR_CMD)
        |=> sh_q[7:0] == $past(fuse_q[1]);
    endproperty
    a_fuse_high_rd: assert property (p_fuse_high_rd) else $error("Wrong fuse high byte");
    property p_done_bit;
        @(posedge tck_i) disable iff (tap_i.reset)
        (tap_i.capture && instr_i == IR_CMD) |=> sh_q[BIT_DONE] == !$past(busy_t);
    endproperty
    a_done_bit: assert property (p_done_bit) else $error("Completion bit wrong");
    property p_lock_and;
        @(posedge tck_i) disable iff (tap_i.reset)
        (wr_stb && mode_q == MODE_LOCKW) |=> lock_q == ($past(lock_q) & $past(dlo_q)) && busy_t;
    endproperty
    a_lock_and: assert property (p_lock_and) else $error("Lock bits not merged");
    property p_fuse_low_wr;
        @(posedge tck_i) disable iff (tap_i.reset)
        (wr_stb && mode_q == MODE_FUSEW && bs_wr == 2'b00) |=> fuse_q[0] == $past(dlo_q);
    endproperty
    a_fuse_low_wr: assert property (p_fuse_low_wr) else $error("Fuse low not written");
    property p_fill_step;
        @(posedge tck_i) disable iff (tap_i.reset)
        (p_bnd && instr_i == IR_FILL && !tap_i.capture) |=> byte_idx_q == $past(byte_idx_q) + 1'b1;
    endproperty
    a_fill_step: assert property (p_fill_step) else $error("Page byte index stuck");
    property p_dump_filler;
        @(posedge tck_i) disable iff (tap_i.reset)
        s_dump_run |=> !dump_fill_q && $past(!tdo_o);
    endproperty
    a_dump_filler: assert property (p_dump_filler) else $error("Filler bits wrong");
    property p_busy_start;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (state_q == ST_IDLE && evt[0] && !evt[1]) |=> nvm_busy_o && cnt_q == CNT_W'(WRITE_CYC - 1);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("Write wait not started");
endmodule : jnp_nvm_prog
`default_nettype wire

//--- jnp_pkg.sv
// Constants, carriers and states for the JTAG NVM programming engine
package jnp_pkg;
    // ****************************************
    // Instruction register codes
    // ****************************************
    localparam int         IR_W    = 4;
    localparam logic [3:0] IR_HOLD = 4'h8; // cpu_hold_reset_instruction
    localparam logic [3:0] IR_KEY  = 4'h9; // programming_key_instruction
    localparam logic [3:0] IR_CMD  = 4'ha; // command_word_instruction
    localparam logic [3:0] IR_FILL = 4'hb; // page_fill_instruction
    localparam logic [3:0] IR_DUMP = 4'hc; // page_dump_instruction
    localparam logic [15:0] PROG_KEY = 16'ha370; // Enable key
    // ****************************************
    // Command word layout
    // ****************************************
    localparam int BIT_LATCH = 14; // Latch strobe, high pulse
    localparam int BIT_WR    = 9;  // Write strobe, low pulse
    localparam int BIT_BS1   = 10; // Byte select 1
    localparam int BIT_BS2   = 11; // Byte select 2
    localparam int BIT_DONE  = 9;  // Completion flag in returned word
    localparam logic [6:0] OP_MODE = 7'h23; // Enter mode
    localparam logic [6:0] OP_AHI  = 7'h07; // Address high byte
    localparam logic [6:0] OP_ALO  = 7'h03; // Address low byte
    localparam logic [6:0] OP_DLO  = 7'h13; // Data low byte
    localparam logic [6:0] OP_DHI  = 7'h17; // Data high byte
    localparam logic [2:0] OP_RW   = 3'h3;  // Top bits of read/write words
    // ****************************************
    // Mode bytes
    // ****************************************
    localparam logic [7:0] MODE_NOP   = 8'h00;
    localparam logic [7:0] MODE_ERASE = 8'h80;
    localparam logic [7:0] MODE_FWR   = 8'h10;
    localparam logic [7:0] MODE_FRD   = 8'h02;
    localparam logic [7:0] MODE_EWR   = 8'h11;
    localparam logic [7:0] MODE_ERD   = 8'h03;
    localparam logic [7:0] MODE_FUSEW = 8'h40;
    localparam logic [7:0] MODE_LOCKW = 8'h20;
    localparam logic [7:0] MODE_FLRD  = 8'h04;
    localparam logic [7:0] MODE_SIG   = 8'h08;
    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [7:0] FUSE_RST      = 8'hff; // All unprogrammed
    localparam logic [7:0] LOCK_RST      = 8'hff;
    localparam int         REF_CLK_MHZ   = 20;
    localparam int         WRITE_WAIT_US = 4500; // write_completion_wait
    localparam int         ERASE_WAIT_US = 9000; // erase_completion_wait
    localparam int         CNT_W         = 24;
    // TAP controller strobes, all on the test clock
    typedef struct packed {
        logic reset;
        logic capture;
        logic shift;
        logic update;
    } jnp_tap_type;
    // Command word split into prefix and argument
    typedef struct packed {
        logic [6:0] op;
        logic [7:0] arg;
    } jnp_cmd_type;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_ERASE = 3'b100
    } jnp_state_type;
endpackage : jnp_pkg

//--- jnp_prog_model.sv
// JTAG programmer model driving the test port
`timescale 1ns/1ps
`default_nettype none
module jnp_prog_model import jnp_pkg::*; (
    input wire logic tdo_i,
    output var logic tck_o = 1'b0,
    output var logic tdi_o = 1'b0,
    output var logic [IR_W-1:0] instr_o = IR_HOLD,
    output var jnp_tap_type tap_o = '0,
    output var logic rx_v_o = 1'b0,
    output var logic [15:0] rx_d_o = '0
);
    // One test clock; tck stands still between frames
    task automatic tick(input logic [3:0] st, input logic d);
        tap_o <= st;
        tdi_o <= st[1] ? d : ~tdi_o; // Idle data keeps toggling
        #62.5 tck_o = 1'b1;
        #62.5 tck_o = 1'b0;
    endtask : tick
    // Capture, LSB-first shift, update, two idle clocks
    task automatic scan(input logic [IR_W-1:0] ir, input logic [15:0] d, input int n);
        rx_d_o = '0;
        instr_o <= ir;
        tick(4'h4, 1'b0);
        for (int i = 0; i < n; i++) begin
            rx_d_o[i] = tdo_i;
            tick(4'h2, d[i]);
        end
        tick(4'h1, 1'b0);
        repeat (2) tick(4'h0, 1'b0);
        rx_v_o = 1'b1;
        #1 rx_v_o = 1'b0;
    endtask : scan
    // Port reset held three clocks
    task automatic tap_reset();
        repeat (3) tick(4'h8, 1'b0);
    endtask : tap_reset
endmodule : jnp_prog_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the programming engine
`timescale 1ns/1ps
`default_nettype none
module testbench import jnp_pkg::*; ;
    localparam logic [23:0] SIG = 24'h3c_a5_5a; // Arbitrary value
    localparam logic [7:0] CAL = 8'h5a; // Arbitrary value
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic tck, tdi, tdo, hold, prog, busy, rx_v;
    logic [IR_W-1:0] instr;
    jnp_tap_type tap;
    logic [15:0] rx_d, dv;
    logic [15:0] lfsr = 16'h1b23; // Seed 6947
    logic [31:0] notes[$], nt; // Mask over expected word
    logic [14:0] fl[4] = '{15'h3e00, 15'h3200, 15'h3600, 15'h3700};
    logic [14:0] wr[10];
    int mismatches = 0;
    int num_checks = 0;
    always #25 ref_clk = ~ref_clk;
    jnp_nvm_prog #(.SIG_BYTES(SIG), .CAL_BYTE(CAL), .WRITE_CYC(200), .ERASE_CYC(400)) u_jnp_nvm_prog (
        .ref_clk_i(ref_clk), .nrst_i(nrst), .tck_i(tck), .tdi_i(tdi), .instr_i(instr), .tap_i(tap),
        .tdo_o(tdo), .cpu_hold_reset_o(hold), .prog_active_o(prog), .nvm_busy_o(busy));
    jnp_prog_model u_jnp_prog_model (.tdo_i(tdo), .tck_o(tck), .tdi_o(tdi), .instr_o(instr),
        .tap_o(tap), .rx_v_o(rx_v), .rx_d_o(rx_d));
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // Oldest note judges each returned word
    always @(posedge rx_v) begin
        nt = notes.pop_front();
        if (nt[31:16] != 16'h0) check(rx_d & nt[31:16], nt[15:0]);
    end
    task automatic dr(input logic [IR_W-1:0] ir, input logic [15:0] d, input int n, input logic [15:0] m = 16'h0,
                      input logic [15:0] e = 16'h0);
        notes.push_back({m, e});
        u_jnp_prog_model.scan(ir, d, n);
    endtask : dr
    // Command word, masked expectation on its capture
    task automatic w(input logic [14:0] d, input logic [14:0] m = 15'h0, input logic [14:0] e = 15'h0);
        notes.push_back({1'b0, m, 1'b0, e});
        u_jnp_prog_model.scan(IR_CMD, {1'b0, d}, 15);
    endtask : w
    // Resync needs a few reference clocks
    task automatic lvl(input logic [1:0] e);
        repeat (10) @(posedge ref_clk);
        #1;
        check({14'h0, hold, prog}, {14'h0, e});
    endtask : lvl
    // Busy must show, then poll with a bound
    task automatic poll(input logic [14:0] d);
        int k;
        check({15'h0, busy}, 16'h1);
        for (k = 0; k < 20; k++) begin
            w(d);
            if (rx_d[9] === 1'b1) break;
        end
        if (k == 20) begin
            mismatches++;
            conclude();
        end
        w(d, 15'h200, 15'h200);
    endtask : poll
    initial begin
        u_jnp_prog_model.tap_reset();
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        dr(IR_HOLD, 16'h1, 1);
        dr(IR_KEY, PROG_KEY ^ 16'h1, 16);
        lvl(2'b10);
        w(15'h2308);
        dr(IR_KEY, PROG_KEY, 16);
        lvl(2'b11);
        w(15'h3300, 15'h3ff, 15'h200);
        w(15'h2308);
        for (int a = 0; a < 3; a++) begin
            w({7'h03, 8'(a)});
            w(15'h3200);
            w(15'h3300);
            w(15'h3300, 15'h3ff, {7'h02, SIG[8*a +: 8]});
        end
        w(15'h2308);
        w(15'h0300);
        w(15'h3600);
        w(15'h3700);
        w(15'h3700, 15'h3ff, {7'h02, CAL});
        w(15'h2304);
        w(15'h3a00);
        foreach (fl[i]) w(fl[i], 15'h3ff, 15'h2ff);
        $display("test reads done");
        w(15'h2380);
        w(15'h3300);
        w(15'h3100);
        w(15'h3300);
        poll(15'h3300);
        lfsr = nxt(lfsr);
        dv = nxt(lfsr);
        wr = '{15'h2310, {7'h07, 6'h00, lfsr[1:0]}, {7'h03, lfsr[9:2]}, {7'h13, dv[7:0]},
               {7'h17, dv[15:8]}, 15'h3700, 15'h7700, 15'h3700, 15'h3500, 15'h3700};
        foreach (wr[i]) w(wr[i]);
        poll(15'h3700);
        w(15'h2302);
        w({7'h07, 6'h3f, lfsr[1:0]});
        w({7'h03, lfsr[9:2]});
        w(15'h3200);
        w(15'h3600, 15'h3ff, {7'h02, dv[7:0]});
        w(15'h3700, 15'h3ff, {7'h02, dv[15:8]});
        w(15'h2310);
        w({7'h03, lfsr[9:7], 5'h00});
        dr(IR_FILL, ~dv, 16);
        w(15'h3700);
        w(15'h3500);
        w(15'h3700);
        poll(15'h3700);
        w(15'h2302);
        dr(IR_DUMP, 16'h0, 16, 16'hffff, {~dv[7:0], 8'h00});
        $display("test flash done");
        w(15'h2340);
        w({7'h13, dv[7:0]});
        w(15'h3100);
        w(15'h3300);
        poll(15'h3300);
        w(15'h2320);
        w({7'h13, 2'h3, dv[13:8]});
        w(15'h3100);
        w(15'h3300);
        poll(15'h3300);
        w(15'h2304);
        w(15'h3200);
        w(15'h3300, 15'h3ff, {7'h02, dv[7:0]});
        w(15'h3600);
        w(15'h3700, 15'h3ff, {7'h02, 2'h3, dv[13:8]});
        wr = '{15'h2311, 15'h0700, 15'h0305, {7'h13, dv[15:8]}, 15'h3700, 15'h7700, 15'h3700, 15'h3300,
               15'h3100, 15'h3300};
        foreach (wr[i]) w(wr[i]);
        poll(15'h3300);
        w(15'h2303);
        w(15'h3200);
        w(15'h3300, 15'h3ff, {7'h02, dv[15:8]});
        $display("test writes done");
        w(15'h2300);
        w(15'h3300);
        dr(IR_KEY, 16'h0, 16);
        dr(IR_HOLD, 16'h0, 1);
        lvl(2'b00);
        conclude();
    end
endmodule : testbench
`default_nettype wire
